// ### asl_line_ctrl.sv
// module: serial line controller top with register port, receiver, handshake and status logic
//
// Summary of operation
// RL1 - divisor-access bit redirects offsets 0 and 1
// RL2 - force-spacing bit holds serial output low
// RL3 - fixed parity sends inverse of even-select
// RL4 - even-select picks even or odd ones count
// RL5 - parity bit sits between data and stop
// RL6 - stop length one, one and a half, or two bits
// RL7 - length field selects five to eight bits
// RL8 - self-loop reroutes serial and handshake lines
// RL9 - self-loop handshake interrupts come from control bits
// RL10 - interrupt-gate bit enables the interrupt output
// RL11 - terminal-ready and send-request outputs are inverted
// RL12 - queue error flag reads zero without queue
// RL13 - idle flag when holding and shift empty
// RL14 - holding-free sets on transfer, clears on write
// RL15 - long low line flags break, waits half bit
// RL16 - bad stop bit flags error, resynchronises
// RL17 - parity mismatch flag, cleared on status read
// RL18 - overwriting unread character flags overflow
// RL19 - data-ready sets on receive, clears on read
// RL20 - error flags raise line status interrupt
// RL21 - upper handshake bits show inverted inputs
// RL22 - lower handshake bits flag input changes
// RL23 - handshake status read clears change bits
// RL24 - spare byte stores and returns any value
`timescale 1ns/1ps
module asl_line_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [2:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_rxd,
  output logic o_txd,
  input wire logic i_cts_n,
  input wire logic i_dsr_n,
  input wire logic i_ri_n,
  input wire logic i_dcd_n,
  output logic o_dtr_n,
  output logic o_rts_n,
  output logic o_irq,
  output logic o_irq_oe
);
  import asl_pkg::*;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} asl_rx_e;

  logic [7:0] lfc_q, spare_q, dll_q, dlm_q, txh_q, rbr_q;
  logic [4:0] hsc_q;
  logic [3:0] ier_q, hs_cur_q, hs_delta_q, hs_now;
  logic [4:0] sync1_q, sync2_q;
  logic [15:0] baud_cnt_q;
  logic tick_q, thre_q, thre_int_q, dr_q, oe_q, pe_q, fe_q, bi_q;
  logic tx_ser, tx_busy, tx_start, loop, rx_in;
  logic wr_data, rd_data, rd_lst, rd_hsr, rd_iid;
  logic [3:0] iid;
  asl_rx_e rx_q;
  logic [3:0] rtick_q;
  logic [2:0] rbit_q;
  logic [7:0] rsh_q, rdat;
  logic rzero_q, rpe_q, rx_done_q, rx_brk_q, rx_fe_q;

  // ----------------------------------------
  // register port decode
  // ----------------------------------------
  assign loop = hsc_q[ASL_HC_LOOP];
  assign wr_data = i_wr && (i_addr == ASL_OFS_DATA) && !lfc_q[ASL_LF_DIVSEL];  // see RL1
  assign rd_data = i_rd && (i_addr == ASL_OFS_DATA) && !lfc_q[ASL_LF_DIVSEL];  // see RL1
  assign rd_lst = i_rd && (i_addr == ASL_OFS_LST);
  assign rd_hsr = i_rd && (i_addr == ASL_OFS_HST);
  assign rd_iid = i_rd && (i_addr == ASL_OFS_IID);

  // software-written control registers; reserved bits are not stored
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lfc_q <= ASL_RST_BYTE;
      hsc_q <= 5'h0;
      ier_q <= 4'h0;
      dll_q <= ASL_RST_BYTE;
      dlm_q <= ASL_RST_BYTE;
      spare_q <= ASL_RST_BYTE;
      txh_q <= ASL_RST_BYTE;
    end else if (i_wr) begin
      case (i_addr)
        ASL_OFS_DATA: begin
          if (lfc_q[ASL_LF_DIVSEL]) begin
            dll_q <= i_wdata;  // see RL1
          end else begin
            txh_q <= i_wdata;
          end
        end
        ASL_OFS_IEN: begin
          if (lfc_q[ASL_LF_DIVSEL]) begin
            dlm_q <= i_wdata;  // see RL1
          end else begin
            ier_q <= i_wdata[3:0];
          end
        end
        ASL_OFS_LFC: lfc_q <= i_wdata;
        ASL_OFS_HSC: hsc_q <= i_wdata[4:0];
        ASL_OFS_SPR: spare_q <= i_wdata;  // see RL24
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // baud tick and pin synchronisers
  // ----------------------------------------
  // divisor 0 stops the ticks, so the line is quiet until software programs a rate
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      baud_cnt_q <= 16'h0;
      tick_q <= 1'b0;
    end else if ({dlm_q, dll_q} == 16'h0 || baud_cnt_q >= {dlm_q, dll_q} - 16'h1) begin
      baud_cnt_q <= 16'h0;
      tick_q <= ({dlm_q, dll_q} != 16'h0);
    end else begin
      baud_cnt_q <= baud_cnt_q + 16'h1;
      tick_q <= 1'b0;
    end
  end

  // pins are asynchronous: two flops before any use
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_q <= 5'h1f;
      sync2_q <= 5'h1f;
    end else begin
      sync1_q <= {i_rxd, i_dcd_n, i_ri_n, i_dsr_n, i_cts_n};
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  assign tx_start = !thre_q && !tx_busy;

  asl_tx_engine u_tx (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_tick(tick_q),
    .i_start(tx_start),
    .i_data(txh_q),
    .i_wlen(lfc_q[1:0]),
    .i_pen(lfc_q[ASL_LF_PEN]),
    .i_eps(lfc_q[ASL_LF_EPS]),
    .i_stick(lfc_q[ASL_LF_STICK]),
    .i_stb(lfc_q[ASL_LF_STB]),
    .o_ser(tx_ser),
    .o_busy(tx_busy)
  );

  // holding-free flag; a write in the same cycle as a transfer wins and keeps thre_q clear
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      thre_q <= 1'b1;
      thre_int_q <= 1'b0;
    end else begin
      if (wr_data) begin
        thre_q <= 1'b0;  // see RL14
      end else if (tx_start) begin
        thre_q <= 1'b1;  // see RL14
      end
      if (tx_start) begin
        thre_int_q <= 1'b1;  // set wins over the clears below
      end else if (wr_data || (rd_iid && iid == ASL_IID_THRE)) begin
        thre_int_q <= 1'b0;
      end
    end
  end

  // serial output: break beats loop, loop holds mark
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_txd <= 1'b1;
    end else if (lfc_q[ASL_LF_BRK]) begin
      o_txd <= 1'b0;  // see RL2
    end else begin
      o_txd <= loop | tx_ser;  // see RL8
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  assign rx_in = loop ? tx_ser : sync2_q[4];  // see RL8
  assign rdat = rsh_q >> (2'h3 - lfc_q[1:0]);

  // mid-bit sampling at half of the oversample count
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_q <= RX_IDLE;
      rtick_q <= 4'h0;
      rbit_q <= 3'h0;
      rsh_q <= 8'h0;
      rzero_q <= 1'b0;
      rpe_q <= 1'b0;
      rx_done_q <= 1'b0;
      rx_brk_q <= 1'b0;
      rx_fe_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      case (rx_q)
        RX_IDLE: begin
          rtick_q <= 4'h0;
          if (!rx_in) begin
            rx_q <= RX_START;
          end
        end
        RX_START: begin
          if (tick_q) begin
            rtick_q <= rtick_q + 4'h1;
            if (rtick_q == 4'(ASL_OVS / 2 - 1)) begin
              rtick_q <= 4'h0;
              rbit_q <= 3'h0;
              rzero_q <= 1'b1;
              rpe_q <= 1'b0;
              rx_q <= rx_in ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA, RX_PAR, RX_STOP: begin
          if (tick_q) begin
            rtick_q <= rtick_q + 4'h1;
            if (rtick_q == 4'(ASL_OVS - 1)) begin
              if (rx_q == RX_DATA) begin
                rsh_q <= {rx_in, rsh_q[7:1]};
                rzero_q <= rzero_q & ~rx_in;
                rbit_q <= rbit_q + 3'h1;
                if (rbit_q == {1'b1, lfc_q[1:0]}) begin  // see RL7
                  rx_q <= lfc_q[ASL_LF_PEN] ? RX_PAR : RX_STOP;  // see RL5
                end
              end else if (rx_q == RX_PAR) begin
                rzero_q <= rzero_q & ~rx_in;
                rpe_q <= rx_in ^ asl_parity(rdat, lfc_q[1:0], lfc_q[ASL_LF_EPS], lfc_q[ASL_LF_STICK]);  // see RL3 see RL4
                rx_q <= RX_STOP;
              end else begin
                // only the first stop bit is checked
                rx_done_q <= 1'b1;  // see RL6
                rx_brk_q <= rzero_q & ~rx_in;  // see RL15
                rx_fe_q <= ~rx_in & ~rzero_q;  // see RL16
                if (rzero_q && !rx_in) begin
                  rx_q <= RX_BRK;
                end else if (!rx_in) begin
                  rx_q <= RX_START;  // low stop taken as next start, see RL16
                end else begin
                  rx_q <= RX_IDLE;
                end
              end
            end
          end
        end
        RX_BRK: begin
          // restart only after the line is high for half a bit
          if (tick_q) begin
            rtick_q <= rx_in ? rtick_q + 4'h1 : 4'h0;
            if (rx_in && rtick_q == 4'(ASL_OVS / 2 - 1)) begin
              rx_q <= RX_IDLE;  // see RL15
            end
          end
        end
        default: rx_q <= RX_IDLE;
      endcase
    end
  end

  // receive buffer and line flags; hardware set wins over a read clear
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rbr_q <= ASL_RST_BYTE;
      dr_q <= 1'b0;
      oe_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      bi_q <= 1'b0;
    end else begin
      if (rx_done_q) begin
        rbr_q <= rx_brk_q ? 8'h00 : rdat;  // a break leaves one zero character
        dr_q <= 1'b1;  // see RL19
      end else if (rd_data) begin
        dr_q <= 1'b0;  // see RL19
      end
      if (rx_done_q && dr_q && !rd_data) begin
        oe_q <= 1'b1;  // see RL18
      end else if (rd_lst) begin
        oe_q <= 1'b0;
      end
      if (rx_done_q && rpe_q) begin
        pe_q <= 1'b1;  // see RL17
      end else if (rd_lst) begin
        pe_q <= 1'b0;
      end
      if (rx_done_q && rx_fe_q) begin
        fe_q <= 1'b1;  // see RL16
      end else if (rd_lst) begin
        fe_q <= 1'b0;
      end
      if (rx_done_q && rx_brk_q) begin
        bi_q <= 1'b1;  // see RL15
      end else if (rd_lst) begin
        bi_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // handshake lines
  // ----------------------------------------
  // status order is carrier, ring, set-ready, clear-to-send
  assign hs_now = loop ? {hsc_q[ASL_HC_IRQG], hsc_q[ASL_HC_AUX], hsc_q[ASL_HC_DTR], hsc_q[ASL_HC_RTS]}  // see RL9
                       : ~sync2_q[3:0];  // see RL21

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hs_cur_q <= 4'h0;
      hs_delta_q <= 4'h0;
    end else begin
      hs_cur_q <= hs_now;
      for (int k = 0; k < 4; k++) begin
        if (k == 2 ? (hs_cur_q[k] && !hs_now[k]) : (hs_cur_q[k] != hs_now[k])) begin
          hs_delta_q[k] <= 1'b1;  // see RL22
        end else if (rd_hsr) begin
          hs_delta_q[k] <= 1'b0;  // see RL23
        end
      end
    end
  end

  // handshake outputs inverted, held inactive in self-loop
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_dtr_n <= 1'b1;
      o_rts_n <= 1'b1;
    end else begin
      o_dtr_n <= loop | ~hsc_q[ASL_HC_DTR];  // see RL8 see RL11
      o_rts_n <= loop | ~hsc_q[ASL_HC_RTS];  // see RL8 see RL11
    end
  end

  // ----------------------------------------
  // interrupt output and read mux
  // ----------------------------------------
  // fixed priority: line status, data, holding-free, handshake
  always_comb begin
    if (ier_q[2] && (oe_q || pe_q || fe_q || bi_q)) begin
      iid = ASL_IID_RLS;  // see RL20
    end else if (ier_q[0] && dr_q) begin
      iid = ASL_IID_RDA;
    end else if (ier_q[1] && thre_int_q) begin
      iid = ASL_IID_THRE;  // see RL14
    end else if (ier_q[3] && (|hs_delta_q)) begin
      iid = ASL_IID_HS;  // see RL9 see RL22
    end else begin
      iid = ASL_IID_NONE;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
      o_irq_oe <= 1'b0;
    end else begin
      o_irq <= (iid != ASL_IID_NONE);
      o_irq_oe <= hsc_q[ASL_HC_IRQG];  // see RL10
    end
  end

  // read data registered one cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= ASL_RST_BYTE;
    end else if (i_rd) begin
      case (i_addr)
        ASL_OFS_DATA: o_rdata <= lfc_q[ASL_LF_DIVSEL] ? dll_q : rbr_q;  // see RL1
        ASL_OFS_IEN: o_rdata <= lfc_q[ASL_LF_DIVSEL] ? dlm_q : {4'h0, ier_q};  // see RL1
        ASL_OFS_IID: o_rdata <= {4'h0, iid};
        ASL_OFS_LFC: o_rdata <= lfc_q;
        ASL_OFS_HSC: o_rdata <= {3'h0, hsc_q};
        ASL_OFS_LST: o_rdata <= {1'b0, thre_q & ~tx_busy, thre_q, bi_q, fe_q, pe_q, oe_q, dr_q};  // see RL12 see RL13
        ASL_OFS_HST: o_rdata <= {hs_cur_q, hs_delta_q};  // see RL21
        default: o_rdata <= spare_q;  // see RL24
      endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  sequence spare_wr_s;
    i_wr && i_addr == ASL_OFS_SPR && !i_rd;
  endsequence
  sequence spare_rd_s;
    i_rd && i_addr == ASL_OFS_SPR && !i_wr;
  endsequence

  break_hold_a: assert property (lfc_q[ASL_LF_BRK] |=> !o_txd) else $error("break not forcing low");  // see RL2
  loop_mark_a: assert property (loop && !lfc_q[ASL_LF_BRK] |=> o_txd) else $error("loop txd not high");  // see RL8
  loop_pins_a: assert property (loop |=> o_dtr_n && o_rts_n) else $error("loop outputs not high");  // see RL8
  dtr_invert_a: assert property (!loop |=> o_dtr_n == !$past(hsc_q[ASL_HC_DTR])) else $error("dtr not inverted");  // see RL11
  irq_gate_a: assert property (##1 o_irq_oe == $past(hsc_q[ASL_HC_IRQG])) else $error("irq gate wrong");  // see RL10
  temt_read_a: assert property (rd_lst |=> o_rdata[6] == $past(thre_q && !tx_busy)) else $error("idle flag wrong");  // see RL13
  thr_clear_a: assert property (wr_data |=> !thre_q ##1 thre_q || tx_busy) else $error("holding flag wrong");  // see RL14
  overrun_a: assert property (rx_done_q && dr_q && !rd_data |=> oe_q) else $error("overrun missed");  // see RL18
  dr_set_a: assert property (rx_done_q |=> dr_q [*1] ##1 1'b1) else $error("data ready missed");  // see RL19
  hs_loop_a: assert property (loop && $stable(hsc_q) [*2] ##0 rd_hsr |=> o_rdata[7:4] == $past(hs_now)) else $error("loop status wrong");  // see RL21
  spare_echo_a: assert property (spare_wr_s ##1 !i_wr ##1 spare_rd_s |=> o_rdata == $past(i_wdata, 3))  // see RL24
    else $error("spare mismatch");
endmodule // asl_line_ctrl

// ### asl_pkg.sv
// package: register map, field positions, reset values and shared helpers of the serial line block
package asl_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [2:0] ASL_OFS_DATA = 3'h0;  // receive/transmit byte or divisor low
  localparam logic [2:0] ASL_OFS_IEN = 3'h1;   // interrupt enable or divisor high
  localparam logic [2:0] ASL_OFS_IID = 3'h2;
  localparam logic [2:0] ASL_OFS_LFC = 3'h3;   // line_format_ctrl
  localparam logic [2:0] ASL_OFS_HSC = 3'h4;   // handshake_ctrl
  localparam logic [2:0] ASL_OFS_LST = 3'h5;   // line_status
  localparam logic [2:0] ASL_OFS_HST = 3'h6;   // handshake_status
  localparam logic [2:0] ASL_OFS_SPR = 3'h7;   // spare_byte
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int ASL_LF_STB = 2;
  localparam int ASL_LF_PEN = 3;
  localparam int ASL_LF_EPS = 4;
  localparam int ASL_LF_STICK = 5;
  localparam int ASL_LF_BRK = 6;
  localparam int ASL_LF_DIVSEL = 7;
  localparam int ASL_HC_DTR = 0;
  localparam int ASL_HC_RTS = 1;
  localparam int ASL_HC_AUX = 2;
  localparam int ASL_HC_IRQG = 3;
  localparam int ASL_HC_LOOP = 4;
  // ----------------------------------------
  // reset values, interrupt codes and timing
  // ----------------------------------------
  localparam logic [7:0] ASL_RST_BYTE = 8'h00;
  localparam logic [3:0] ASL_IID_NONE = 4'h1;
  localparam logic [3:0] ASL_IID_RLS = 4'h6;
  localparam logic [3:0] ASL_IID_RDA = 4'h4;
  localparam logic [3:0] ASL_IID_THRE = 4'h2;
  localparam logic [3:0] ASL_IID_HS = 4'h0;
  localparam int ASL_OVS = 16;  // baud ticks per bit
  localparam logic [5:0] ASL_STOP1 = 6'h10;
  localparam logic [5:0] ASL_STOP15 = 6'h18;
  localparam logic [5:0] ASL_STOP2 = 6'h20;
  // parity of the used data bits; fixed parity sends the inverse of even-select
  function automatic logic asl_parity(input logic [7:0] d, input logic [1:0] wlen,
                                      input logic eps, input logic stick);
    logic [7:0] mask;
    mask = 8'hff >> (2'h3 - wlen);
    asl_parity = stick ? ~eps : ((^(d & mask)) ^ ~eps);
  endfunction
endpackage

// ### asl_remote_term.sv
// remote serial terminal model that sends and captures frames on the line
`timescale 1ns/1ps
module asl_remote_term #(
  parameter int BIT_CLKS = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_txd,
  output logic o_rxd
);
  // the line rests at mark between frames, as a pulled-up line would
  initial o_rxd = 1'b1;
  // send n bits lsb first, one bit time each; past bit 11 the line is held low
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      o_rxd = (i < 12) ? bits[i] : 1'b0;
      repeat (BIT_CLKS) @(negedge i_sys_clk);
    end
    o_rxd = 1'b1;
  endtask
  // capture n bits at mid-bit; no wait after the last one so a following start edge is not missed
  task automatic recv(output logic [11:0] bits, output time t0, input int n);
    bits = 12'h000;
    @(negedge i_txd);
    t0 = $time;
    repeat (BIT_CLKS / 2) @(posedge i_sys_clk);
    for (int i = 0; i < n; i++) begin
      if (i > 0)
        repeat (BIT_CLKS) @(posedge i_sys_clk);
      bits[i] = i_txd;
    end
  endtask
endmodule // asl_remote_term

// ### asl_tx_engine.sv
// module: transmit shift engine producing one serial frame per start request
`timescale 1ns/1ps
module asl_tx_engine (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_tick,
  input wire logic i_start,
  input wire logic [7:0] i_data,
  input wire logic [1:0] i_wlen,
  input wire logic i_pen,
  input wire logic i_eps,
  input wire logic i_stick,
  input wire logic i_stb,
  output logic o_ser,
  output logic o_busy
);
  import asl_pkg::*;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asl_tx_e;
  asl_tx_e st_q;
  logic [5:0] tick_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic par_q;
  logic [5:0] last;

  // stop length in ticks: half extra bit only for 5-bit characters
  always_comb begin
    if (st_q != TX_STOP) begin
      last = 6'(ASL_OVS - 1);
    end else if (!i_stb) begin
      last = ASL_STOP1 - 6'h1;  // see RL6
    end else if (i_wlen == 2'h0) begin
      last = ASL_STOP15 - 6'h1;  // see RL6
    end else begin
      last = ASL_STOP2 - 6'h1;  // see RL6
    end
  end

  // serial level per state, parity between last data bit and stop
  always_comb begin
    case (st_q)
      TX_START: o_ser = 1'b0;
      TX_DATA: o_ser = sh_q[0];
      TX_PAR: o_ser = par_q;  // see RL5
      default: o_ser = 1'b1;
    endcase
  end
  assign o_busy = (st_q != TX_IDLE);

  // frame sequencer; start taken only while idle
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= TX_IDLE;
      tick_q <= 6'h0;
      bit_q <= 3'h0;
      sh_q <= 8'h0;
      par_q <= 1'b0;
    end else if (st_q == TX_IDLE) begin
      if (i_start) begin
        st_q <= TX_START;
        sh_q <= i_data;
        par_q <= asl_parity(i_data, i_wlen, i_eps, i_stick);  // see RL3 see RL4
        tick_q <= 6'h0;
        bit_q <= 3'h0;
      end
    end else if (i_tick) begin
      if (tick_q != last) begin
        tick_q <= tick_q + 6'h1;
      end else begin
        tick_q <= 6'h0;
        case (st_q)
          TX_START: st_q <= TX_DATA;
          TX_DATA: begin
            sh_q <= sh_q >> 1;
            if (bit_q == {1'b1, i_wlen}) begin  // 5..8 data bits, see RL7
              st_q <= i_pen ? TX_PAR : TX_STOP;  // see RL5
            end else begin
              bit_q <= bit_q + 3'h1;
            end
          end
          TX_PAR: st_q <= TX_STOP;
          default: st_q <= TX_IDLE;
        endcase
      end
    end
  end
endmodule // asl_tx_engine

// ### tb_asl_line_ctrl.sv
// self-checking bench for the serial line controller against a remote terminal
`timescale 1ns/1ps
module tb_asl_line_ctrl;
  import asl_pkg::*;
  logic i_sys_clk, i_reset_n, i_wr, i_rd, rxd;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, o_rdata;
  logic i_cts_n, i_dsr_n, i_ri_n, i_dcd_n;
  logic o_txd, o_dtr_n, o_rts_n, o_irq, o_irq_oe;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] fmt [8] = '{8'h00, 8'h04, 8'h05, 8'h0a, 8'h1b, 8'h2b, 8'h3a, 8'h0f};

  asl_line_ctrl u_asl_line_ctrl (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_rxd(rxd), .o_txd(o_txd),
    .i_cts_n(i_cts_n), .i_dsr_n(i_dsr_n), .i_ri_n(i_ri_n), .i_dcd_n(i_dcd_n), .o_dtr_n(o_dtr_n),
    .o_rts_n(o_rts_n), .o_irq(o_irq), .o_irq_oe(o_irq_oe));
  asl_remote_term u_term (.i_sys_clk(i_sys_clk), .i_txd(o_txd), .o_rxd(rxd));

  // ----------------------------------------
  // clock, hang guard and helpers
  // ----------------------------------------
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  // the whole run needs well under half this many cycles
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // strobes rise and fall at falling edges; one idle cycle between accesses
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_sys_clk);
    i_wr = 1'b0;
    @(negedge i_sys_clk);
  endtask
  // read data is sampled three falling edges after the taking edge; it holds until the next read
  task automatic rdc(input string nm, input logic [2:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
    i_addr = a;
    i_rd = 1'b1;
    @(negedge i_sys_clk);
    i_rd = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    chk(nm, exp, o_rdata & m);
  endtask
  // expected frame: start, data lsb first, parity, stop; bad[0] flips parity, bad[1] lowers stop
  function automatic logic [11:0] frm(input logic [7:0] fc, input logic [7:0] d, input logic [1:0] bad);
    logic [11:0] f;
    int wl;
    logic [7:0] dm;
    wl = 5 + int'(fc[1:0]);
    dm = d & (8'hff >> (2'h3 - fc[1:0]));
    f = 12'hfff;
    f[0] = 1'b0;
    for (int i = 0; i < wl; i++) f[i + 1] = d[i];
    if (fc[3])
      f[wl + 1] = (fc[5] ? ~fc[4] : (fc[4] ? ^dm : ~^dm)) ^ bad[0];
    f[wl + 1 + int'(fc[3])] = ~bad[1];
    return f;
  endfunction
  // two back-to-back transmit frames, then one received frame, in format fc
  task automatic xfer(input logic [7:0] fc);
    logic [11:0] b0, b1, fm;
    time t0, t1;
    int n, sp;
    n = 7 + int'(fc[1:0]) + int'(fc[3]);
    fm = (12'h1 << n) - 12'h1;
    sp = (n - 1) * 16 + (fc[2] ? ((fc[1:0] == 2'h0) ? 24 : 32) : 16);
    wr(ASL_OFS_LFC, fc);
    fork
      begin
        u_term.recv(b0, t0, n);
        u_term.recv(b1, t1, n);
      end
      begin
        wr(ASL_OFS_DATA, 8'hc6);
        wr(ASL_OFS_DATA, 8'h39);
        rdc("lst busy", ASL_OFS_LST, 8'h00);
      end
    join
    chk("tx frame", frm(fc, 8'hc6, 2'h0) & fm, b0);
    chk("tx frame2", frm(fc, 8'h39, 2'h0) & fm, b1);
    chk("stop time", 12'h1, 12'((t1 - t0) / 20 >= sp && (t1 - t0) / 20 <= sp + 2));
    u_term.send(frm(fc, 8'h5a, 2'h0), n);
    rdc("lst ready", ASL_OFS_LST, 8'h61);
    rdc("rx byte", ASL_OFS_DATA, 8'h5a & (8'hff >> (2'h3 - fc[1:0])));
    rdc("lst read", ASL_OFS_LST, 8'h60);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {i_wr, i_rd, i_addr, i_wdata} = '0;
    {i_cts_n, i_dsr_n, i_ri_n, i_dcd_n} = 4'hf;
    i_reset_n = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    chk("pins", 12'h1c, {o_txd, o_dtr_n, o_rts_n, o_irq, o_irq_oe});
    rdc("lfc", ASL_OFS_LFC, 8'h00);
    rdc("hsc", ASL_OFS_HSC, 8'h00);
    rdc("lst", ASL_OFS_LST, 8'h60);
    rdc("hst", ASL_OFS_HST, 8'h00);
    wr(ASL_OFS_SPR, 8'ha5);
    rdc("spare", ASL_OFS_SPR, 8'ha5);
    wr(ASL_OFS_LST, 8'hff);
    rdc("lst ro", ASL_OFS_LST, 8'h60);
    // divisor of one gives one baud tick per clock
    wr(ASL_OFS_LFC, 8'h80);
    wr(ASL_OFS_DATA, 8'h01);
    wr(ASL_OFS_IEN, 8'h00);
    rdc("div lo", ASL_OFS_DATA, 8'h01);
    wr(ASL_OFS_LFC, 8'h03);
    rdc("ien", ASL_OFS_IEN, 8'h00);
    wr(ASL_OFS_HSC, 8'h01);
    chk("dtr rts", 12'h1, {o_dtr_n, o_rts_n});
    wr(ASL_OFS_HSC, 8'h02);
    chk("dtr rts", 12'h2, {o_dtr_n, o_rts_n});
    wr(ASL_OFS_LFC, 8'h40);
    chk("brk", 12'h0, o_txd);
    wr(ASL_OFS_LFC, 8'h03);
    chk("brk off", 12'h1, o_txd);
    // handshake pins: change flags, read clears, ring trailing edge
    i_cts_n = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    rdc("hst cts", ASL_OFS_HST, 8'h11);
    rdc("hst clr", ASL_OFS_HST, 8'h10);
    i_ri_n = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    rdc("hst ri", ASL_OFS_HST, 8'h50);
    i_ri_n = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    rdc("hst ring_trail", ASL_OFS_HST, 8'h14);
    foreach (fmt[k]) xfer(fmt[k]);
    // self-loop: status mirrors control bits and the line is turned inward
    wr(ASL_OFS_LFC, 8'h03);
    wr(ASL_OFS_IEN, 8'h08);
    wr(ASL_OFS_HSC, 8'h18);
    repeat (3) @(negedge i_sys_clk);
    chk("irq hs", 12'h3, {o_irq, o_irq_oe});
    rdc("hst loop", ASL_OFS_HST, 8'h89);
    chk("irq hs clr", 12'h0, o_irq);
    wr(ASL_OFS_HSC, 8'h1f);
    chk("loop pins", 12'h3, {o_dtr_n, o_rts_n});
    rdc("hst loop2", ASL_OFS_HST, 8'hf3);
    fork
      u_term.send(frm(8'h03, 8'h3c, 2'h0), 10);
      begin
        wr(ASL_OFS_DATA, 8'ha5);
        repeat (40) @(negedge i_sys_clk);
        chk("loop txd", 12'h1, o_txd);
      end
    join
    repeat (100) @(negedge i_sys_clk);
    rdc("lst loop", ASL_OFS_LST, 8'h61);
    rdc("rx loop", ASL_OFS_DATA, 8'ha5);
    // line errors with the status interrupt enabled
    wr(ASL_OFS_HSC, 8'h08);
    wr(ASL_OFS_IEN, 8'h04);
    wr(ASL_OFS_LFC, 8'h1b);
    u_term.send(frm(8'h1b, 8'h33, 2'h1), 11);
    repeat (4) @(negedge i_sys_clk);
    chk("irq rls", 12'h3, {o_irq, o_irq_oe});
    rdc("lst par", ASL_OFS_LST, 8'h65);
    chk("irq rls clr", 12'h0, o_irq);
    rdc("rx par", ASL_OFS_DATA, 8'h33);
    u_term.send(12'h000, 24);
    repeat (20) @(negedge i_sys_clk);
    rdc("lst brk", ASL_OFS_LST, 8'h11, 8'h1f);
    rdc("rx brk", ASL_OFS_DATA, 8'h00);
    u_term.send(frm(8'h1b, 8'h21, 2'h0), 11);
    u_term.send(frm(8'h1b, 8'h42, 2'h0), 11);
    rdc("lst ovr", ASL_OFS_LST, 8'h63);
    rdc("lst ovr clr", ASL_OFS_LST, 8'h61);
    rdc("rx ovr", ASL_OFS_DATA, 8'h42);
    u_term.send(frm(8'h1b, 8'h44, 2'h2), 11);
    repeat (40) @(negedge i_sys_clk);
    rdc("lst frm", ASL_OFS_LST, 8'h08, 8'h1e);
    results();
  end
endmodule // tb_asl_line_ctrl
